// file: verilog/psbw_params.svh
// Constants for the burst, WAIT and configuration word logic.
// Assumes inclusion by bare name from files under verilog/.
`ifndef PSBW_PARAMS_SVH
`define PSBW_PARAMS_SVH

// Configuration word power-up value and writable bits
`define PSBW_CFG_RESET 16'h1D1F
`define PSBW_CFG_WMASK 16'hFD3F
// Register select code on address bits 19:18
`define PSBW_SEL_HI 19
`define PSBW_SEL_LO 18
`define PSBW_SEL_CFG 2'b10
// Field positions inside the configuration word
`define PSBW_BL_HI 2
`define PSBW_BL_LO 0
`define PSBW_WRAP_BIT 3
`define PSBW_DRV_HI 5
`define PSBW_DRV_LO 4
`define PSBW_WCFG_BIT 8
`define PSBW_WPOL_BIT 10
`define PSBW_LAT_HI 13
`define PSBW_LAT_LO 11
// Latency codes and pipeline offset
`define PSBW_LAT_MIN_CODE 3'b010
`define PSBW_LAT_MAX_CODE 3'b110
`define PSBW_LAT_DEF_CODE 3'b011
`define PSBW_LAT_OFFSET 3'b010
// Words per row, as a column width
`define PSBW_COL_W 8

`endif

// file: verilog/psbw_pkg.sv
// Types shared by the burst controller and its helpers.
// Assumes the constant header is compiled alongside.
package psbw_pkg;

    // Burst controller states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LAT  = 2'b01,
        ST_XFER = 2'b10,
        ST_END  = 2'b11
    } psbw_state_t;

    // Burst length codes
    typedef enum logic [2:0] {
        four_word_burst       = 3'b001,
        eight_word_burst      = 3'b010,
        sixteen_word_burst    = 3'b011,
        thirty_two_word_burst = 3'b100,
        continuous_burst      = 3'b111
    } psbw_blen_t;

    // Output drive settings
    typedef enum logic [1:0] {
        DRV_FULL    = 2'b00,
        DRV_HALF    = 2'b01,
        DRV_QUARTER = 2'b10,
        DRV_RSVD    = 2'b11
    } psbw_drive_t;

endpackage

// file: verilog/psbw_buf2.sv
// Small valid/ready buffer between array fetch and the bus stage.
// Assumes one clock; flush empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none

module psbw_buf2 #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

    logic [W-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;

    // Pointer step with wrap at depth
    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Full and empty; an empty buffer passes its input through
    assign in_ready = (count_reg != FULL_CNT);
    assign out_valid = (count_reg != '0) | in_valid;
    assign out_data = (count_reg == '0) ? in_data : mem_reg[rd_ptr_reg];

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Pointer and occupancy tracking
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else if (flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= step(wr_ptr_reg);
            if (pop) rd_ptr_reg <= step(rd_ptr_reg);
            if (push && !pop) count_reg <= count_reg + 1'b1;
            else if (pop && !push) count_reg <= count_reg - 1'b1;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk) begin
        if (push && !flush) mem_reg[wr_ptr_reg] <= in_data;
    end
endmodule

`default_nettype wire

// file: verilog/psbw_addr_seq.sv
// Burst address sequencer: wrap within block, linear to row end,
// or continuous. Assumes load and advance are never high together.
`timescale 1ns/1ps
`default_nettype none

module psbw_addr_seq #(
    parameter int ADDR_W = 22,
    parameter int COL_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [ADDR_W-1:0] start_addr,
    input wire logic wrap_en,
    input wire logic fixed_len,
    input wire logic [5:0] len_words,
    input wire logic advance,
    output logic [ADDR_W-1:0] addr,
    output logic last,
    output logic done
);
    logic [ADDR_W-1:0] addr_reg;
    logic [5:0] left_reg;
    logic done_reg;

    // Column arithmetic inside the current row
    wire [COL_W-1:0] col = addr_reg[COL_W-1:0];
    wire [COL_W-1:0] len_col = COL_W'(len_words);
    wire [COL_W-1:0] mask = len_col - {{(COL_W-1){1'b0}}, 1'b1};
    wire [COL_W-1:0] col_inc = col + {{(COL_W-1){1'b0}}, 1'b1};
    wire wrap_block = wrap_en & fixed_len;
    wire [COL_W-1:0] next_col = wrap_block ? ((col & ~mask) | (col_inc & mask)) : col_inc; // RQ4 RQ7
    wire row_end = ~wrap_en & (col == {COL_W{1'b1}}); // RQ6 RQ7 RQ3
    wire count_end = fixed_len & (left_reg == 6'h01); // RQ1

    assign last = row_end | count_end;
    assign addr = addr_reg;
    assign done = done_reg;

    // Step on each transferred word, stop after the last
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_reg <= '0;
            left_reg <= '0;
            done_reg <= 1'b0;
        end else if (load) begin
            addr_reg <= start_addr;
            left_reg <= len_words;
            done_reg <= 1'b0;
        end else if (advance && !done_reg) begin
            if (last) done_reg <= 1'b1;
            else begin
                addr_reg <= {addr_reg[ADDR_W-1:COL_W], next_col};
                left_reg <= left_reg - 6'h01;
            end
        end
    end
endmodule

`default_nettype wire

// file: verilog/psbw_burst.sv
// Synchronous burst engine of a pseudo-static memory: configuration
// word, burst sequencing, latency count and WAIT generation.
// Assumes the host bus runs on clk and the array answers reads by ack.
`timescale 1ns/1ps
`default_nettype none
`include "psbw_params.svh"

// What this block does
// RQ1: Bursts of 4, 8, 16 or 32 words for both reads and writes.
// RQ2: Length codes 001, 010, 011, 100 fixed; 111 continuous; others reserved.
// RQ3: Continuous burst runs on consecutive words, stops at row end. The code stops there in linear mode only; with wrap it rolls to word 0.
// RQ4: Wrap cycles inside the aligned block of burst length words.
// RQ5: Burst mode bit clear means wrap, set means linear.
// RQ6: Linear burst ends early at the row end.
// RQ7: A row is 256 words; continuous wrap rolls to word 0.
// RQ8: Drive field 00 full, 01 half, 10 quarter, 11 reserved.
// RQ9: Half drive at power-up and during test.
// RQ10: Timing bit 0: WAIT changes together with data validity.
// RQ11: Timing bit 1: WAIT changes one clock ahead of data validity.
// RQ12: Host moves data only in cycles that WAIT marks valid.
// RQ13: Polarity bit picks asserted WAIT level, opposite when deasserted.
// RQ14: Polarity set asserts high; cleared asserts low.
// RQ15: Power-up WAIT is active high with one-clock-ahead timing.
// RQ16: Power-up burst is continuous and linear.
// RQ17: Latency field sets clocks from burst start to first data.
// RQ18: Only codes two to six, three to seven clocks, are used.
// RQ19: Codes 010 to 110 give 3 to 7 clocks; 011 is default.
// RQ20: Latency field starts at its power-up code.
module psbw_burst #(
    parameter int ADDR_W = 22,
    parameter int DATA_W = 16,
    parameter int BUF_DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce_b,
    input wire logic adv_b,
    input wire logic we_b,
    input wire logic cre,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_b,
    output logic wait_out,
    output logic wait_oe_b,
    input wire logic test_mode,
    output psbw_pkg::psbw_drive_t drive_strength,
    output logic [15:0] bus_configuration_word,
    output logic [ADDR_W-1:0] arr_addr,
    output logic arr_rd_req,
    input wire logic arr_rd_ack,
    input wire logic [DATA_W-1:0] arr_rd_data,
    output logic arr_wr_en,
    output logic [DATA_W-1:0] arr_wr_data
);
    import psbw_pkg::*;

    // ====================
    // Decode helpers
    // ====================

    // Words per burst; zero marks continuous or reserved
    function automatic logic [5:0] blen_words(input logic [2:0] code);
        case (code)
            four_word_burst: blen_words = 6'h04;
            eight_word_burst: blen_words = 6'h08;
            sixteen_word_burst: blen_words = 6'h10;
            thirty_two_word_burst: blen_words = 6'h20;
            default: blen_words = 6'h00;
        endcase
    endfunction

    // Latency load value: code minus pipeline offset
    function automatic logic [2:0] lat_load(input logic [2:0] code);
        logic [2:0] use_code;
        use_code = code;
        if (code < `PSBW_LAT_MIN_CODE || code > `PSBW_LAT_MAX_CODE) begin
            use_code = `PSBW_LAT_DEF_CODE;
        end
        lat_load = use_code - `PSBW_LAT_OFFSET;
    endfunction

    // ====================
    // State
    // ====================
    psbw_state_t state_reg;
    psbw_state_t state_next;
    logic [15:0] bus_configuration_reg;
    logic [2:0] lat_cnt_reg;
    logic write_reg;
    logic pre_valid_reg;
    logic [DATA_W-1:0] hold_reg;
    logic dq_valid_reg;
    logic [DATA_W-1:0] dq_out_reg;
    logic cfg_drive_reg;
    logic arr_wr_en_reg;
    logic [DATA_W-1:0] arr_wr_data_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic tm_meta_reg;
    logic tm_sync_reg;

    // ====================
    // Configuration fields
    // ====================
    wire [2:0] bl_code = bus_configuration_reg[`PSBW_BL_HI:`PSBW_BL_LO];
    wire [5:0] len_words = blen_words(bl_code); // RQ2
    wire fixed_len = (len_words != 6'h00); // RQ2 RQ3
    wire wrap_en = ~bus_configuration_reg[`PSBW_WRAP_BIT]; // RQ5
    wire [1:0] drv_field = bus_configuration_reg[`PSBW_DRV_HI:`PSBW_DRV_LO];
    wire wait_lead = bus_configuration_reg[`PSBW_WCFG_BIT];
    wire wait_act_high = bus_configuration_reg[`PSBW_WPOL_BIT];
    wire [2:0] lat_code = bus_configuration_reg[`PSBW_LAT_HI:`PSBW_LAT_LO];

    // ====================
    // Host bus decode
    // ====================
    wire adv_cycle = ~ce_b & ~adv_b;
    wire burst_start = adv_cycle & ~cre;
    wire cfg_hit = adv_cycle & cre & (addr[`PSBW_SEL_HI:`PSBW_SEL_LO] == `PSBW_SEL_CFG);
    wire cfg_write = cfg_hit & ~we_b;
    wire cfg_read = cfg_hit & we_b;
    wire active = (state_reg != ST_IDLE);
    wire lat_done = active & (lat_cnt_reg == 3'b000);

    // ====================
    // Sequencers and buffer
    // ====================
    logic [ADDR_W-1:0] fetch_addr;
    logic fetch_done;
    logic bus_last;
    logic bus_done;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [DATA_W-1:0] buf_out_data;

    // Array-side read fetch, stalled by the buffer
    wire fetch_ok = active & ~write_reg & ~fetch_done & buf_in_ready;
    wire fetch_take = fetch_ok & arr_rd_ack;
    // Write word sampled in the valid window
    wire wr_capture = active & write_reg & dq_valid_reg; // RQ12
    // Bus stage picks a word two cycles before it is shown
    wire sel_valid = lat_done & ~bus_done & (write_reg | buf_out_valid); // RQ17
    wire pop = sel_valid & ~write_reg;
    wire flush = ~active | burst_start;

    // Array-side address sequencer
    psbw_addr_seq #(
        .ADDR_W(ADDR_W),
        .COL_W(`PSBW_COL_W)
    ) u_fetch_seq (
        .clk(clk),
        .rst_b(rst_b),
        .load(burst_start),
        .start_addr(addr),
        .wrap_en(wrap_en),
        .fixed_len(fixed_len),
        .len_words(len_words),
        .advance(fetch_take | wr_capture),
        .addr(fetch_addr),
        .last(),
        .done(fetch_done)
    );

    // Bus-side word counter, same sequence
    psbw_addr_seq #(
        .ADDR_W(ADDR_W),
        .COL_W(`PSBW_COL_W)
    ) u_bus_seq (
        .clk(clk),
        .rst_b(rst_b),
        .load(burst_start),
        .start_addr(addr),
        .wrap_en(wrap_en),
        .fixed_len(fixed_len),
        .len_words(len_words),
        .advance(sel_valid),
        .addr(),
        .last(bus_last),
        .done(bus_done)
    );

    // Read words between array and bus stage
    psbw_buf2 #(
        .W(DATA_W),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(clk),
        .rst_b(rst_b),
        .flush(flush),
        .in_valid(fetch_take),
        .in_ready(buf_in_ready),
        .in_data(arr_rd_data),
        .out_valid(buf_out_valid),
        .out_ready(pop),
        .out_data(buf_out_data)
    );

    // ====================
    // Burst state machine
    // ====================

    // Next state; chip deselect always ends the burst
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (burst_start) state_next = ST_LAT;
            ST_LAT: if (lat_cnt_reg == 3'b000) state_next = ST_XFER;
            ST_XFER: if (sel_valid && bus_last) state_next = ST_END; // RQ6 RQ3
            ST_END: state_next = ST_END;
            default: state_next = ST_IDLE;
        endcase
        if (burst_start) state_next = ST_LAT;
        else if (ce_b) state_next = ST_IDLE;
    end

    // State and latency counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            lat_cnt_reg <= 3'b000;
            write_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (burst_start) begin
                lat_cnt_reg <= lat_load(lat_code); // RQ17 RQ18 RQ19
                write_reg <= ~we_b; // RQ1
            end else if (lat_cnt_reg != 3'b000) begin
                lat_cnt_reg <= lat_cnt_reg - 3'b001;
            end
        end
    end

    // ====================
    // Configuration word
    // ====================

    // Written through the address bus; reserved bits stay zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_configuration_reg <= `PSBW_CFG_RESET; // RQ15 RQ16 RQ20 RQ9
        end else if (cfg_write) begin
            bus_configuration_reg <= addr[15:0] & `PSBW_CFG_WMASK;
        end
    end

    // ====================
    // Data pipeline
    // ====================

    // Pick stage, then show stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_valid_reg <= 1'b0;
            dq_valid_reg <= 1'b0;
        end else if (flush) begin
            pre_valid_reg <= 1'b0;
            dq_valid_reg <= 1'b0;
        end else begin
            pre_valid_reg <= sel_valid;
            dq_valid_reg <= pre_valid_reg;
        end
    end

    // Data registers; configuration read shares the output
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_reg <= '0;
            dq_out_reg <= '0;
        end else begin
            if (pop) hold_reg <= buf_out_data;
            if (cfg_read) dq_out_reg <= bus_configuration_reg;
            else if (pre_valid_reg && !write_reg) dq_out_reg <= hold_reg;
        end
    end

    // Drive window for a configuration read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) cfg_drive_reg <= 1'b0;
        else if (ce_b) cfg_drive_reg <= 1'b0;
        else if (cfg_read) cfg_drive_reg <= 1'b1;
    end

    // Write words to the array
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arr_wr_en_reg <= 1'b0;
            arr_wr_data_reg <= '0;
            wr_addr_reg <= '0;
        end else begin
            arr_wr_en_reg <= wr_capture & ~fetch_done;
            if (wr_capture) begin
                arr_wr_data_reg <= dq_in;
                wr_addr_reg <= fetch_addr;
            end
        end
    end

    // ==========================================================
    // Test pin synchroniser
    // ==========================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tm_meta_reg <= 1'b0;
            tm_sync_reg <= 1'b0;
        end else begin
            tm_meta_reg <= test_mode;
            tm_sync_reg <= tm_meta_reg;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================

    // WAIT asserted outside the valid window, lead or aligned
    wire win_valid = wait_lead ? pre_valid_reg : dq_valid_reg; // RQ10 RQ11
    wire wait_asserted = active & ~win_valid;
    assign wait_out = wait_act_high ? wait_asserted : ~wait_asserted; // RQ13 RQ14
    assign wait_oe_b = ~(active | cfg_drive_reg);

    // Drive setting; test forces half, reserved code falls back to half
    wire drv_half = tm_sync_reg | (drv_field == DRV_RSVD); // RQ9
    assign drive_strength = drv_half ? DRV_HALF : psbw_drive_t'(drv_field); // RQ8

    assign dq_out = dq_out_reg;
    assign dq_oe_b = ~((active & ~write_reg) | cfg_drive_reg);
    assign bus_configuration_word = bus_configuration_reg;
    assign arr_rd_req = fetch_ok;
    assign arr_addr = arr_wr_en_reg ? wr_addr_reg : fetch_addr;
    assign arr_wr_en = arr_wr_en_reg;
    assign arr_wr_data = arr_wr_data_reg;
endmodule

`default_nettype wire

// file: tb/psbw_burst_props.sv
// Checker for the burst engine: configuration word, WAIT and writes.
// Assumes binding to psbw_burst; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module psbw_burst_props #(
    parameter int ADDR_W = 22
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce_b,
    input wire logic adv_b,
    input wire logic we_b,
    input wire logic cre,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wait_out,
    input wire logic wait_oe_b,
    input wire logic dq_oe_b,
    input wire logic test_mode,
    input wire psbw_pkg::psbw_drive_t drive_strength,
    input wire logic [15:0] bus_configuration_word,
    input wire logic arr_wr_en
);
    import psbw_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========================================
    // Burst tracking
    wire logic start = !ce_b && !adv_b;
    wire logic cfg_wr = start && cre && !we_b && addr[19:18] == 2'h2;
    wire logic [2:0] lcode = bus_configuration_word[13:11];
    wire logic wpol = bus_configuration_word[10];
    wire logic lead = bus_configuration_word[8];
    wire logic ok_code = lcode >= 3'h2 && lcode <= 3'h6;
    logic on_reg;
    logic wr_reg;
    logic [7:0] cyc_reg;
    logic [2:0] lat_reg;
    // Cycle count since start, first valid WAIT cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            on_reg <= 1'b0;
            wr_reg <= 1'b0;
            cyc_reg <= 8'h00;
            lat_reg <= 3'h0;
        end else if (start && !cre) begin
            on_reg <= 1'b1;
            wr_reg <= !we_b;
            cyc_reg <= 8'h01;
            lat_reg <= (ok_code ? lcode + 3'h1 : 3'h4) - {2'h0, lead};
        end else begin
            on_reg <= on_reg && !ce_b;
            cyc_reg <= (cyc_reg == 8'hFF) ? cyc_reg : cyc_reg + 8'h01;
        end
    end
    // ==========================================
    // Properties
    property p_cfg_write;
        cfg_wr |=> bus_configuration_word == ($past(addr[15:0]) & 16'hFD3F);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("cfg load");
    property p_cfg_keep;
        !cfg_wr |=> $stable(bus_configuration_word);
    endproperty
    a_cfg_keep: assert property (p_cfg_keep)
        else $error("cfg kept");
    property p_power_up;
        !$past(rst_b) |-> bus_configuration_word == 16'h1D1F && drive_strength == DRV_HALF;
    endproperty
    a_power_up: assert property (p_power_up)
        else $error("power-up");
    property p_drive;
        !test_mode && !$past(test_mode) && !$past(test_mode, 2)
            && $stable(bus_configuration_word) |-> drive_strength ==
            (bus_configuration_word[5:4] == 2'h3 ? DRV_HALF
            : psbw_drive_t'(bus_configuration_word[5:4]));
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive");
    property p_drive_test;
        test_mode [*3] |-> drive_strength == DRV_HALF;
    endproperty
    a_drive_test: assert property (p_drive_test)
        else $error("test drive");
    property p_wait_delay;
        on_reg && cyc_reg < {5'h00, lat_reg} |-> wait_out == wpol && !wait_oe_b;
    endproperty
    a_wait_delay: assert property (p_wait_delay)
        else $error("wait early");
    property p_release;
        ce_b && $past(ce_b) |-> wait_oe_b && dq_oe_b;
    endproperty
    a_release: assert property (p_release)
        else $error("pins idle");
    property p_wr_now;
        on_reg && wr_reg && !ce_b && !lead && wait_out != wpol |=> arr_wr_en;
    endproperty
    a_wr_now: assert property (p_wr_now)
        else $error("write now");
    property p_wr_lead;
        on_reg && wr_reg && !ce_b && lead && wait_out != wpol ##1 !ce_b |=> arr_wr_en;
    endproperty
    a_wr_lead: assert property (p_wr_lead)
        else $error("write lead");
endmodule
`default_nettype wire

// file: tb/psbw_array_model.sv
// Array stand-in: answers fetches with the low 16 address bits.
// Assumes one clock; slow mode answers every second cycle.
`timescale 1ns/1ps
`default_nettype none
module psbw_array_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic arr_rd_req,
    input wire logic [21:0] arr_addr,
    output logic arr_rd_ack,
    output logic [15:0] arr_rd_data
);
    logic ph_reg;
    // Stall phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) ph_reg <= 1'b0;
        else ph_reg <= !ph_reg;
    end
    // Inverse word when not answering
    assign arr_rd_ack = arr_rd_req && (!slow || ph_reg);
    assign arr_rd_data = arr_rd_ack ? arr_addr[15:0] : ~arr_addr[15:0];
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Testbench for psbw_burst: config access, bursts, drive settings.
// Assumes the array model stands on the array side.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import psbw_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce_b, adv_b, we_b, cre, test_mode, slow;
    logic [21:0] addr, arr_addr;
    logic [15:0] dq_in, dq_out, bcw, arr_rd_data, arr_wr_data, cw, rv;
    logic dq_oe_b, wait_out, wait_oe_b, arr_rd_req, arr_rd_ack, arr_wr_en;
    psbw_drive_t drive_strength;
    int bad_count = 0;
    int checked = 0;
    int first_k;
    logic [15:0] got[$], wa[$], wd[$];
    always #50 clk = ~clk;
    psbw_burst DUT (.clk(clk), .rst_b(rst_b), .ce_b(ce_b), .adv_b(adv_b), .we_b(we_b),
        .cre(cre), .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_b(dq_oe_b),
        .wait_out(wait_out), .wait_oe_b(wait_oe_b), .test_mode(test_mode),
        .drive_strength(drive_strength), .bus_configuration_word(bcw),
        .arr_addr(arr_addr), .arr_rd_req(arr_rd_req), .arr_rd_ack(arr_rd_ack),
        .arr_rd_data(arr_rd_data), .arr_wr_en(arr_wr_en), .arr_wr_data(arr_wr_data));
    psbw_array_model u_arr (.clk(clk), .rst_b(rst_b), .slow(slow),
        .arr_rd_req(arr_rd_req), .arr_addr(arr_addr), .arr_rd_ack(arr_rd_ack),
        .arr_rd_data(arr_rd_data));
    // Written words seen at the array side
    always @(negedge clk) begin
        if (arr_wr_en === 1'b1) begin
            wa.push_back(arr_addr[15:0]);
            wd.push_back(arr_wr_data);
        end
    end
    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cfg(input logic [15:0] v, input logic rd, output logic [15:0] r);
        @(negedge clk);
        ce_b = 1'b0;
        adv_b = 1'b0;
        cre = 1'b1;
        we_b = rd;
        addr = {6'h08, v};
        @(negedge clk);
        adv_b = 1'b1;
        cre = 1'b0;
        r = dq_out;
        ce_b = 1'b1;
        @(negedge clk);
    endtask
    task automatic burst(input logic [21:0] a, input logic wr, input int n);
        logic pw, w, v;
        got.delete();
        wa.delete();
        wd.delete();
        first_k = -1;
        pw = 1'b1;
        @(negedge clk);
        ce_b = 1'b0;
        adv_b = 1'b0;
        we_b = !wr;
        addr = a;
        for (int k = 1; k <= n; k++) begin
            @(negedge clk);
            adv_b = 1'b1;
            dq_in = 16'hB000 + k[15:0];
            w = (wait_out === cw[10]);
            v = cw[8] ? !pw : !w;
            pw = w;
            if (v && first_k < 0) first_k = k;
            if (v) got.push_back(wr ? dq_in : dq_out);
        end
        ce_b = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    function automatic int wcount(logic [21:0] a, logic [2:0] bl, logic wrap);
        int len;
        len = (bl >= 3'h1 && bl <= 3'h4) ? (2 << bl) : 0;
        if (len == 0) return wrap ? 999 : 256 - a[7:0];
        if (wrap || 256 - a[7:0] >= len) return len;
        return 256 - a[7:0];
    endfunction
    function automatic logic [15:0] waddr(logic [21:0] a, int j, logic [2:0] bl, logic wrap);
        int len;
        logic [7:0] c;
        len = (bl >= 3'h1 && bl <= 3'h4) ? (2 << bl) : 256;
        c = wrap ? 8'((a[7:0] & ~(len - 1)) | ((a[7:0] + j) & (len - 1))) : 8'(a[7:0] + j);
        return {a[15:8], c};
    endfunction
    task automatic check(input logic [21:0] a, input logic wr, input int lat);
        if (wcount(a, cw[2:0], !cw[3]) < 999) chk(got.size(), wcount(a, cw[2:0], !cw[3]));
        if (lat > 0) chk(first_k, lat);
        foreach (got[j]) begin
            chk(wr ? wa[j] : got[j], waddr(a, j, cw[2:0], !cw[3]));
            if (wr) chk(wd[j], got[j]);
        end
    endtask
    // ==========================================
    // Main sequence
    initial begin
        ce_b = 1'b1;
        adv_b = 1'b1;
        we_b = 1'b1;
        cre = 1'b0;
        test_mode = 1'b0;
        slow = 1'b0;
        addr = 22'h00_0000;
        dq_in = 16'h0000;
        cw = 16'h1D1F;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        chk(bcw, cw);
        chk(drive_strength, DRV_HALF);
        cfg(16'h0000, 1'b1, rv);
        chk(rv, cw);
        burst(22'h01_00FE, 1'b0, 12);
        check(22'h01_00FE, 1'b0, 4);
        // Every length, latency code, polarity and timing
        for (int i = 0; i < 5; i++) begin
            cw = {2'h0, 3'(i + 2), i[1], 1'b0, i[0], 4'h1, 1'b0, 3'(i < 4 ? i + 1 : 7)};
            cfg(cw, 1'b0, rv);
            chk(bcw, cw);
            burst(i < 4 ? 22'h00_0107 : 22'h00_02FD, i[0] ^ i[1], 45);
            check(i < 4 ? 22'h00_0107 : 22'h00_02FD, i[0] ^ i[1], i + 3);
        end
        cw = 16'h1D1A;
        cfg(cw, 1'b0, rv);
        burst(22'h00_03FB, 1'b1, 20);
        check(22'h00_03FB, 1'b1, 4);
        // Stalling array
        cw = 16'h1D11;
        cfg(cw, 1'b0, rv);
        slow = 1'b1;
        burst(22'h00_0006, 1'b0, 30);
        check(22'h00_0006, 1'b0, 0);
        slow = 1'b0;
        for (int d = 0; d < 4; d++) begin
            cfg(16'h1D0F | 16'(d << 4), 1'b0, rv);
            chk(drive_strength, (d == 3) ? 1 : d);
        end
        cfg(16'h1D0F, 1'b0, rv);
        test_mode = 1'b1;
        repeat (3) @(negedge clk);
        chk(drive_strength, DRV_HALF);
        test_mode = 1'b0;
        cfg(16'hFFFF, 1'b0, rv);
        cfg(16'h0000, 1'b1, rv);
        chk(rv, 16'hFD3F);
        end_of_test();
    end
    // Watchdog
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end
endmodule
bind psbw_burst psbw_burst_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .rst_b(rst_b),
    .ce_b(ce_b), .adv_b(adv_b), .we_b(we_b), .cre(cre), .addr(addr), .wait_out(wait_out),
    .wait_oe_b(wait_oe_b), .dq_oe_b(dq_oe_b), .test_mode(test_mode),
    .drive_strength(drive_strength), .bus_configuration_word(bus_configuration_word),
    .arr_wr_en(arr_wr_en));
`default_nettype wire
